// ---- logic/fault_guard.v ----
// software fault watchdog: control register, prescaler, down-counter, reset pulse
//
// Implementation choice: strobed register access.
`include "fault_guard_map.vh"
module fault_guard
#(
   parameter PRESCALE_CYCLES = `PRESCALE_CYCLES,
   parameter WAKE_DELAY      = `WAKE_DELAY_CYCLES
)
(
   input  wire       clk,
   input  wire       rst,
   input  wire [7:0] addr,
   input  wire [7:0] wr_data,
   input  wire       wr_en,
   input  wire       rd_en,
   output reg  [7:0] rd_data,
   input  wire       hw_guard_opt,
   input  wire       halt_reset_opt,
   input  wire       halt_req,
   input  wire       wait_req,
   input  wire       ext_wakeup,
   output reg        reset_req,
   output reg        reset_pin_n,
   output reg        halted
);
   localparam RUN  = 2'd0;
   localparam HALT = 2'd1;
   localparam WAKE = 2'd2;
   localparam integer PULSE_LEN = `RESET_PULSE_CYCLES;

   reg        activate_r;
   reg [6:0]  count_r;
   reg [13:0] presc_r;
   reg [12:0] wake_r;
   reg [1:0]  state_r;
   reg [3:0]  pulse_r;
   reg [1:0]  state_nxt;
   wire       sel      = (addr == `GUARD_CONTROL_OFFSET);
   wire       reg_wr   = wr_en && sel;
   wire       active   = activate_r || hw_guard_opt;
   wire       counting = (state_r == RUN);             // wait_req unused on purpose
   wire       tick     = counting && (presc_r == PRESCALE_CYCLES - 1);
   // a refresh landing on the rolling tick reloads the counter, so it must not fire
   wire       roll     = tick && !reg_wr && (count_r == `COUNT_MIDPOINT) && active;
   wire       sw_rst   = reg_wr && wr_data[`GUARD_ACTIVATE_BIT] && !wr_data[`COUNT_TOP_BIT];
   wire       halt_rst = halt_req && counting && halt_reset_opt && active;
   wire       fire     = (roll || sw_rst || halt_rst) && (pulse_r == 4'd0);

   always @*
   begin
      state_nxt = state_r;
      case (state_r)
         RUN:  if (halt_req && !halt_rst) state_nxt = HALT;
         HALT: if (ext_wakeup) state_nxt = WAKE;
         WAKE: if (wake_r == WAKE_DELAY - 1) state_nxt = RUN;
         default: state_nxt = RUN;
      endcase
   end

   // the block's own reset request comes back through rst, clearing everything
   always @(posedge clk)
   begin
      if (rst)
      begin
         activate_r  <= 1'b0;
         count_r     <= 7'h7f;
         presc_r     <= 14'd0;
         wake_r      <= 13'd0;
         state_r     <= RUN;
         pulse_r     <= 4'd0;
         reset_req   <= 1'b0;
         reset_pin_n <= 1'b1;
         rd_data     <= 8'h00;
         halted      <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         halted  <= (state_nxt != RUN);
         wake_r  <= (state_r == WAKE) ? wake_r + 13'd1 : 13'd0;
         if (reg_wr)
         begin
            if (wr_data[`GUARD_ACTIVATE_BIT])
               activate_r <= 1'b1;       // set only
            count_r <= wr_data[6:0];
            presc_r <= 14'd0;
         end
         else if (counting)
         begin
            if (tick)
            begin
               presc_r <= 14'd0;
               count_r <= count_r - 7'd1;
            end
            else
               presc_r <= presc_r + 14'd1;
         end
         // pulse stretched to about 500ns at this clock rate
         if (fire)
            pulse_r <= PULSE_LEN[3:0];
         else if (pulse_r != 4'd0)
            pulse_r <= pulse_r - 4'd1;
         reset_req   <= fire || (pulse_r > 4'd1);
         reset_pin_n <= !(fire || (pulse_r > 4'd1));
         if (rd_en && sel)
            rd_data <= {activate_r, count_r};
         else
            rd_data <= 8'h00;
      end
   end
endmodule // fault_guard

// ---- logic/fault_guard_map.vh ----
// constants for the software fault watchdog
// Contract
// - counter steps down once every 12288 cpu clocks via fixed prescaler
// - low six bits give 64 programmable steps before top bit clears
// - active and count 40h to 3Fh starts reset, pin low about 500ns
// - at 8 MHz, FFh gives 98.304 ms, C0h gives 1.536 ms
// - software can set activation bit, only reset clears it
// - watchdog disabled after any reset, stays enabled until next reset
// - write with activate set and top bit clear gives immediate reset
// - hardware option makes watchdog always active, activation bit ignored
// - wait state leaves counting and reset behaviour untouched
// - reset-on-halt option with active watchdog: halt resets immediately
// - otherwise halt freezes counter, no reset until interrupt or reset
// - after interrupt wake-up, counting resumes 4096 cpu clocks later
// - a reset ending halt returns watchdog to disabled reset state
// - control register resets to 7Fh
// - bit 7 activation, bits 6:0 counter, msb first
`ifndef FAULT_GUARD_MAP_VH
`define FAULT_GUARD_MAP_VH
`define GUARD_CONTROL_OFFSET   8'h24
`define GUARD_CONTROL_RESET    8'h7f
`define GUARD_ACTIVATE_BIT     7
`define COUNT_TOP_BIT          6
`define PRESCALE_CYCLES        12288
`define WAKE_DELAY_CYCLES      4096
`define RESET_PULSE_NS         500
`define CLK_PERIOD_NS          100
`define RESET_PULSE_CYCLES     (`RESET_PULSE_NS / `CLK_PERIOD_NS)
`define COUNT_MIDPOINT         7'h40
`endif

// ---- bench/fault_guard_checker.sv ----
// port assertions for the fault watchdog
module fault_guard_checker(
   input logic       clk,
   input logic       rst,
   input logic [7:0] addr,
   input logic [7:0] wr_data,
   input logic       wr_en,
   input logic       rd_en,
   input logic [7:0] rd_data,
   input logic       hw_guard_opt,
   input logic       halt_reset_opt,
   input logic       halt_req,
   input logic       reset_req,
   input logic       reset_pin_n,
   input logic       halted
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   wire w = wr_en && addr == 8'h24;
   wire r = rd_en && addr == 8'h24;
   chk_pin_inverse: assert property (reset_pin_n == !reset_req) else $error("pin");
   chk_pulse_five: assert property ($rose(reset_req) |-> reset_req[*5] ##1 !reset_req) else $error("len");
   chk_soft_reset: assert property (w && wr_data[7:6] == 2'b10 && !reset_req |=> reset_req) else $error("soft");
   chk_refresh_safe: assert property (w && wr_data[6] && !halt_req |=> !$rose(reset_req)) else $error("ref");
   chk_read_back: assert property (w ##1 r && !wr_en |=> rd_data[6:0] == $past(wr_data[6:0], 2)) else $error("rb");
   chk_read_idle: assert property (!r |=> rd_data == 8'h00) else $error("idle");
   chk_halt_reset: assert property (halt_req && halt_reset_opt && hw_guard_opt && !halted && !reset_req
      |=> reset_req) else $error("halt");
   chk_halt_freeze: assert property (halted && !wr_en |=> !$rose(reset_req)) else $error("frz");
   cover property ($rose(reset_req));
   cover property ($fell(halted));
   cover property (r);
endmodule // fault_guard_checker
bind fault_guard fault_guard_checker fault_guard_checker_inst(.clk, .rst, .addr, .wr_data, .wr_en, .rd_en, .rd_data,
   .hw_guard_opt, .halt_reset_opt, .halt_req, .reset_req, .reset_pin_n, .halted);

// ---- bench/tb_top.sv ----
// self-checking bench for the fault watchdog
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, rst = 1, wr_en = 0, rd_en = 0, hw = 0, hro = 0, hq = 0, wk = 0;
   logic [7:0] addr = 0, wd = 0;
   wire [7:0] rd;
   wire rq, pn, hl;
   int fail_count = 0, samples_checked = 0;
   always #50 clk = ~clk;
   // short prescale keeps the run brief; wait input held busy to show it is ignored
   fault_guard #(.PRESCALE_CYCLES(8), .WAKE_DELAY(4)) fault_guard_inst(.clk, .rst, .addr, .wr_data(wd), .wr_en,
      .rd_en, .rd_data(rd), .hw_guard_opt(hw), .halt_reset_opt(hro), .halt_req(hq), .wait_req(1'b1),
      .ext_wakeup(wk), .reset_req(rq), .reset_pin_n(pn), .halted(hl));
   task step; @(posedge clk); #1; endtask
   task chk(logic c, string m); samples_checked++; fail_count += (c !== 1'b1);
      if (c !== 1'b1) $display("CHECK FAILED %0t %s", $time, m); endtask
   task rs; rst <= 1; repeat (3) step; rst <= 0; endtask
   task wr(logic [7:0] a, d); addr <= a; wd <= d; wr_en <= 1; step; wr_en <= 0; endtask
   task rdx(logic [7:0] e); addr <= 8'h24; rd_en <= 1; step; rd_en <= 0; chk(rd === e, "read"); endtask
   task halt_in; hq <= 1; step; hq <= 0; endtask
   // the chip's own reset follows each pulse, so the bench applies it after every wait that expects a reset
   task waitrst(int n, logic e); for (int i = 0; i < n && rq !== 1'b1; i++) step;
      chk((rq === 1'b1) === e, "reset"); if (rq === 1'b1) repeat (6) step; if (e) rs; endtask
   task t_timeout; rdx(8'h7f);
      wr(8'h24, 8'hc1);
      rdx(8'hc1);
      waitrst(13, 0);
      waitrst(4, 1);
      rdx(8'h7f);
      $display("timeout test ended"); endtask
   task t_soft; wr(8'h24, 8'h80); waitrst(2, 1);
      wr(8'h10, 8'h80); wr(8'h24, 8'h41); waitrst(30, 0);
      $display("soft test ended"); endtask
   task t_hw; hw <= 1; wr(8'h24, 8'h41); waitrst(20, 1);
      hw <= 0; $display("hw test ended"); endtask
   task t_halt; wr(8'h24, 8'hc1);
      halt_in; waitrst(40, 0);
      wk <= 1; step; wk <= 0; waitrst(3, 0); waitrst(24, 1);
      $display("halt test ended"); endtask
   task t_halt_rst; hro <= 1; hw <= 1; wr(8'h24, 8'hc5); halt_in; waitrst(2, 1);
      hro <= 0; hw <= 0; $display("halt reset test ended"); endtask
   task tally_and_finish;
      $display("checks %0d failures %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial
   begin
      #100us;
      fail_count++;
      tally_and_finish;
   end
   initial
   begin
      rs;
      t_timeout;
      t_soft;
      t_hw;
      t_halt;
      t_halt_rst;
      tally_and_finish;
   end
endmodule // tb_top
